// *** core/alert_pin_routing.sv ***
// Alert pin routing: two routing registers steering sources to two pins
//
// Overview of operation
// - Read/write routing register at 27h connects sources to the first pin.
// - Identical read/write routing register at 28h serves the second pin.
// - Routing acts on a pin only while its function select picks alert.
// - A source reaches a pin only if globally enabled and routed there.
// - Bits 23:20 overcurrent, bits 19:16 undercurrent, channels 1 to 4.
// - Bits 15:12 overvoltage, bits 11:8 undervoltage, channels 1 to 4.
// - Bits 7:4 overpower, channels 1 to 4.
// - Bit 3 routes the accumulator fullness or overflow alert.
// - Bit 2 routes the sample counter fullness or overflow alert.
// - First register bit 1 gives a 5 us pin pulse per conversion cycle.
// - While the first pin is an alert output its slow input is unused.
// - Routing bits reset to zero; bit 0 is unimplemented, reads zero.
// - Second register bit 1 gives a 5 us pin pulse per conversion cycle.
`timescale 1ns/1ps
`default_nettype none

module alert_pin_routing (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire alert_route_pkg::reg_req_type reg_req_in,
  output var  logic [23:0]                reg_rdata_out,
  output var  logic                       reg_rvalid_out,
  input  wire logic [23:0]                alert_cond_in,
  input  wire logic [23:0]                alert_enable_in,
  input  wire logic [1:0]                 alert_func_in,
  input  wire logic                       conv_done_in,
  input  wire logic [1:0]                 pin_in,
  output var  logic [1:0]                 pin_out,
  output var  logic [1:0]                 pin_oe_out,
  output var  logic [1:0]                 pin_level_out
);

  // ****************************************
  // Storage
  // ****************************************
  logic [1:0][23:0] route_ff;
  logic [1:0]       pulse_active;
  logic [1:0]       source_hit;
  logic [1:0]       nxt_assert;
  logic [1:0]       pin_sync1_ff;
  logic [1:0]       pin_sync2_ff;
  logic [1:0]       pin_out_ff;
  logic [1:0]       pin_oe_ff;
  logic [1:0]       pin_level_ff;
  logic [23:0]      rdata_ff;
  logic             rvalid_ff;

  // ****************************************
  // Per-pin routing, pulse and pin drive
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < alert_route_pkg::PIN_COUNT; p++) begin : g_pin
      logic route_wr;
      logic pulse_start;

      assign route_wr = reg_req_in.wr &&
                        reg_req_in.addr == alert_route_pkg::ROUTE_ADDR[p];

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          route_ff[p] <= alert_route_pkg::ROUTE_RESET;
        end else if (route_wr) begin
          // Bit 0 does not exist in hardware, so it never stores a one
          route_ff[p] <= reg_req_in.wdata &
                         alert_route_pkg::ROUTE_IMPL_MASK;
        end
      end

      // Enabled and routed sources combine as a plain OR
      assign source_hit[p] = |(alert_cond_in & alert_enable_in &
                               route_ff[p] &
                               alert_route_pkg::SOURCE_MASK);

      assign pulse_start = conv_done_in && alert_func_in[p] &&
        route_ff[p][alert_route_pkg::CONV_PULSE_BIT];

      alert_pulse_timer #(
        .CYCLES (alert_route_pkg::PULSE_CYCLES)
      ) u_pulse (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .start_in   (pulse_start),
        .active_out (pulse_active[p])
      );

      // Routing is ignored entirely unless the pin is in alert function
      assign nxt_assert[p] = alert_func_in[p] &&
                             (source_hit[p] || pulse_active[p]);

      // Open-drain style: drive low only while asserting, else release
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_oe_ff[p]  <= 1'b0;
          pin_out_ff[p] <= 1'b1;
        end else begin
          pin_oe_ff[p]  <= nxt_assert[p];
          pin_out_ff[p] <= ~nxt_assert[p];
        end
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_sync1_ff[p] <= 1'b0;
          pin_sync2_ff[p] <= 1'b0;
        end else begin
          pin_sync1_ff[p] <= pin_in[p];
          pin_sync2_ff[p] <= pin_sync1_ff[p];
        end
      end

      // Input function of the pin is cut off while it serves as alert
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_level_ff[p] <= 1'b0;
        end else begin
          pin_level_ff[p] <= alert_func_in[p] ? 1'b0
                                              : pin_sync2_ff[p];
        end
      end
    end
  endgenerate

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff  <= 24'h000000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        case (reg_req_in.addr)
          alert_route_pkg::ROUTE_ADDR[0]: begin
            rdata_ff <= route_ff[0];
          end
          alert_route_pkg::ROUTE_ADDR[1]: begin
            rdata_ff <= route_ff[1];
          end
          default: begin
            rdata_ff <= 24'h000000;
          end
        endcase
      end
    end
  end

  assign reg_rdata_out  = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;
  assign pin_out        = pin_out_ff;
  assign pin_oe_out     = pin_oe_ff;
  assign pin_level_out  = pin_level_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  route1_write_a : assert property (
    reg_req_in.wr && reg_req_in.addr == 8'h27 |=>
    route_ff[0] == ($past(reg_req_in.wdata) & 24'hFFFFFE))
    else $error("first routing register did not take the write");

  route2_write_a : assert property (
    reg_req_in.wr && reg_req_in.addr == 8'h28 ##1 !reg_req_in.wr |=>
    route_ff[1] == ($past(reg_req_in.wdata, 2) & 24'hFFFFFE))
    else $error("second routing register did not take the write");

  func_gate_a : assert property (
    !alert_func_in[0] |=> !pin_oe_out[0] && pin_out[0])
    else $error("pin driven outside alert function");

  gate_cause_a : assert property (
    pin_oe_out[1] |-> $past(alert_func_in[1]) &&
    ($past(source_hit[1]) || $past(pulse_active[1])))
    else $error("pin asserted without enabled routed source");

  overcurrent_route_a : assert property (
    alert_func_in[0] && alert_cond_in[23] && alert_enable_in[23] &&
    route_ff[0][23] |=> pin_oe_out[0])
    else $error("overcurrent channel 1 not routed");

  undervoltage_route_a : assert property (
    alert_func_in[1] && alert_cond_in[8] && alert_enable_in[8] &&
    route_ff[1][8] |=> pin_oe_out[1])
    else $error("undervoltage channel 4 not routed");

  overpower_route_a : assert property (
    alert_func_in[0] && alert_cond_in[4] && alert_enable_in[4] &&
    route_ff[0][4] |=> pin_oe_out[0])
    else $error("overpower channel 4 not routed");

  accum_route_a : assert property (
    alert_func_in[1] && alert_cond_in[3] && alert_enable_in[3] &&
    route_ff[1][3] |=> pin_oe_out[1])
    else $error("accumulator fullness not routed");

  counter_route_a : assert property (
    alert_func_in[0] && alert_cond_in[2] && alert_enable_in[2] &&
    route_ff[0][2] |=> pin_oe_out[0])
    else $error("sample counter fullness not routed");

  // Pin follows the function select a cycle late, so only the first
  // pin cycle is tied to it; the timer must then keep running
  conv_pulse_a : assert property (
    conv_done_in && alert_func_in[0] && route_ff[0][1] ##1
    alert_func_in[0] |=> pin_oe_out[0] ##1 pulse_active[0] [*7])
    else $error("conversion pulse missing on first pin");

  conv_pulse2_a : assert property (
    conv_done_in && alert_func_in[1] && route_ff[1][1] |=>
    ##1 (pin_oe_out[1] || !$past(alert_func_in[1])))
    else $error("conversion pulse missing on second pin");

  slow_block_a : assert property (
    alert_func_in[0] |=> pin_level_out[0] == 1'b0)
    else $error("slow input visible in alert function");

  bit_zero_a : assert property (
    route_ff[0][0] == 1'b0 && route_ff[1][0] == 1'b0 &&
    reg_rdata_out[0] == 1'b0)
    else $error("unimplemented bit 0 reads one");

  or_combine_a : assert property (
    alert_func_in[1] && source_hit[1] |=> pin_oe_out[1])
    else $error("routed active source did not assert pin");

  cover_route_hit_c : cover property (
    alert_func_in[0] && source_hit[0] ##1 pin_oe_out[0]);

  cover_pulse_c : cover property (
    conv_done_in && alert_func_in[1] && route_ff[1][1]);

  cover_read_c : cover property (
    reg_req_in.rd && reg_req_in.addr == 8'h28 ##1 reg_rvalid_out);

  cover_slow_c : cover property (!alert_func_in[0] && pin_level_out[0]);

endmodule : alert_pin_routing

`default_nettype wire

// *** common/alert_route_pkg.sv ***
// Package: constants and types for the alert pin routing block
package alert_route_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int              ADDR_W          = 8;
  localparam int              DATA_W          = 24;
  localparam int              PIN_COUNT       = 2;
  localparam logic [1:0][7:0] ROUTE_ADDR      = {8'h28, 8'h27};
  localparam logic [23:0]     ROUTE_RESET     = 24'h000000;
  localparam logic [23:0]     ROUTE_IMPL_MASK = 24'hFFFFFE;
  localparam logic [23:0]     SOURCE_MASK     = 24'hFFFFFC;

  // ****************************************
  // Field positions (channel 1 at the top of each group)
  // ****************************************
  localparam int OVERCURRENT_MSB  = 23;
  localparam int UNDERCURRENT_MSB = 19;
  localparam int OVERVOLTAGE_MSB  = 15;
  localparam int UNDERVOLTAGE_MSB = 11;
  localparam int OVERPOWER_MSB    = 7;
  localparam int ACCUM_FULL_BIT   = 3;
  localparam int COUNT_FULL_BIT   = 2;
  localparam int CONV_PULSE_BIT   = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ  = 200;
  localparam int PULSE_TIME_NS = 5000;
  localparam int PULSE_CYCLES  = (PULSE_TIME_NS * CLK_FREQ_MHZ) / 1000;

  // ****************************************
  // Register access request
  // ****************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

endpackage : alert_route_pkg

// *** core/alert_pulse_timer.sv ***
// Retriggerable fixed-length pulse timer
`timescale 1ns/1ps
`default_nettype none

module alert_pulse_timer #(
  parameter int CYCLES = 1000
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  output var  logic active_out
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic          active_ff;

  // A new start restarts the full length rather than extending it
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff    <= '0;
      active_ff <= 1'b0;
    end else if (start_in) begin
      cnt_ff    <= CW'(CYCLES - 1);
      active_ff <= 1'b1;
    end else if (active_ff) begin
      if (cnt_ff == '0) begin
        active_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign active_out = active_ff;

  // ****************************************
  // Checks
  // ****************************************
  pulse_start_a : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    start_in |=> active_ff && cnt_ff == CW'(CYCLES - 1))
    else $error("pulse timer did not load on start");

  pulse_end_a : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    active_ff && cnt_ff == '0 && !start_in |=> !active_ff)
    else $error("pulse timer did not stop at zero");

endmodule : alert_pulse_timer

`default_nettype wire

// *** dv/alert_host_model.sv ***
// Host model: pull-ups on both alert pins and a low-pulse meter
`timescale 1ns/1ps
`default_nettype none

module alert_host_model (
  input  wire logic             clock_in,
  input  wire logic [1:0]       pin_out_in,
  input  wire logic [1:0]       pin_oe_in,
  input  wire logic [1:0]       host_pull_in,
  output var  logic [1:0]       wire_out,
  output var  logic [1:0][15:0] low_len_out
);
  int cnt [2] = '{0, 0};

  // Open drain with pull-up, so a released pin reads high
  always_comb wire_out = ~((pin_oe_in & ~pin_out_in) | host_pull_in);

  initial low_len_out = '0;

  // Length of the last completed low period, in clock cycles
  always @(posedge clock_in) begin
    for (int p = 0; p < 2; p++) begin
      if (!wire_out[p]) begin
        cnt[p]++;
      end else if (cnt[p] != 0) begin
        low_len_out[p] = 16'(cnt[p]);
        cnt[p] = 0;
      end
    end
  end
endmodule : alert_host_model

`default_nettype wire

// *** dv/alert_pin_routing_tb_top.sv ***
// Self-checking bench for the alert pin routing block
`timescale 1ns/1ps
`default_nettype none

module alert_pin_routing_tb_top;
  logic                         clock_in;
  logic                         rst_n_in;
  alert_route_pkg::reg_req_type req;
  logic [23:0]                  rdata, cond, en, d;
  logic                         rvalid, conv;
  logic [1:0]                   func, pout, poe, plvl, pwire, pull;
  logic [1:0][15:0]             low_len;
  logic [7:0]                   a;
  logic [23:0]                  mrt [2];
  logic [1:0]                   exp_oe;
  int                           cnt [2];
  int                           fails, n_checks;

  alert_pin_routing dut_u (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .alert_cond_in(cond), .alert_enable_in(en), .alert_func_in(func),
    .conv_done_in(conv), .pin_in(pwire), .pin_out(pout),
    .pin_oe_out(poe), .pin_level_out(plvl)
  );

  alert_host_model host_u (
    .clock_in(clock_in), .pin_out_in(pout), .pin_oe_in(poe),
    .host_pull_in(pull), .wire_out(pwire), .low_len_out(low_len)
  );

  task automatic end_sim();
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] ad, input logic [23:0] dv);
    @(posedge clock_in);
    req <= '{1'b1, 1'b0, ad, dv};
    @(posedge clock_in);
    req <= '{1'b0, 1'b0, ad, dv};
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] ad, input logic [23:0] ev);
    @(posedge clock_in);
    req <= '{1'b0, 1'b1, ad, 24'h000000};
    @(posedge clock_in);
    req <= '{1'b0, 1'b0, ad, 24'h000000};
    @(negedge clock_in);
    chk(rvalid === 1'b1 && rdata === ev, "read data");
  endtask : rd_reg

  // ****************************************
  // Reference model, compared every cycle
  // ****************************************
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      mrt = '{24'h000000, 24'h000000};
      cnt = '{0, 0};
      exp_oe = 2'b00;
    end else begin
      chk(poe === exp_oe && pout === ~exp_oe, "pin drive");
      for (int p = 0; p < 2; p++) begin
        exp_oe[p] = func[p] & ((|(cond & en & mrt[p] & 24'hFFFFFC))
                    | (cnt[p] > 0));
        if (conv && func[p] && mrt[p][1])
          cnt[p] = 1000;
        else if (cnt[p] > 0)
          cnt[p]--;
        if (req.wr && req.addr == alert_route_pkg::ROUTE_ADDR[p])
          mrt[p] = req.wdata & 24'hFFFFFE;
      end
    end
  end

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #200000;
    fails++;
    end_sim();
  end

  initial begin
    rst_n_in = 1'b0;
    req = '0;
    cond = '0;
    en = '0;
    func = '0;
    conv = 1'b0;
    pull = '0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'h08EE));
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd_reg(8'h27, 24'h000000);
    rd_reg(8'h28, 24'h000000);
    // Random routing, sources, enables and function selects
    for (int i = 0; i < 60; i++) begin
      a = (i % 5 == 0) ? 8'h29 : alert_route_pkg::ROUTE_ADDR[i % 2];
      d = 24'($urandom);
      if (i % 6 != 0)
        d[1] = 1'b0;
      wr_reg(a, d);
      // Expected word from the written data, not from the racing model
      rd_reg(a, (a == 8'h29) ? 24'h000000
                             : (d & 24'hFFFFFE));
      repeat (20) begin
        @(posedge clock_in);
        cond <= 24'($urandom & $urandom & $urandom);
        en <= 24'($urandom & $urandom);
        func <= 2'($urandom);
        conv <= ($urandom % 40 == 0);
      end
    end
    // Second reset in mid-run clears routing and timers
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    en <= '0;
    func <= 2'b00;
    conv <= 1'b0;
    cond <= '0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd_reg(8'h27, 24'h000000);
    for (int p = 0; p < 2; p++) begin
      wr_reg(alert_route_pkg::ROUTE_ADDR[p], 24'h000002);
      @(posedge clock_in);
      func <= 2'b11;
      conv <= 1'b1;
      @(posedge clock_in);
      conv <= 1'b0;
      repeat (1100) @(posedge clock_in);
      chk(low_len[p] === 16'd1000, "pulse width");
    end
    func <= 2'b00;
    pull <= 2'b01;
    repeat (5) @(posedge clock_in);
    chk(plvl === 2'b10, "pin input level");
    func <= 2'b11;
    repeat (5) @(posedge clock_in);
    chk(plvl === 2'b00, "input masked in alert mode");
    end_sim();
  end
endmodule : alert_pin_routing_tb_top

`default_nettype wire
